// File: design/data_move_pkg.sv
// Shared types and constants of the data move unit
// Behaviour
// - Eight 32-bit general registers outside 64-bit mode
// - Six 16-bit segment pointer registers
// - Hold 32-bit status and control flags register
// - 32-bit instruction pointer outside 64-bit mode
// - Sixteen registers in 64-bit mode, upper need prefix
// - 64-bit operand needs prefix encoding in 64-bit mode
// - Flags register widens to 64 bits
// - Instruction pointer widens to 64 bits
// - Quadword operands allowed, width chosen by request
// - Reject legacy-only instructions in 64-bit mode
// - No memory-to-memory or segment-to-segment copy
// - Copy supports the listed source and destination paths
// - Gated copy moves only when condition holds
// - Gated copy: 16/32/64-bit, memory or register source
// - False condition leaves destination, advances pointer
// - Alternate spellings share one condition encoding
// - Feature report shows gated copy is implemented
package data_move_pkg;

	// Register file sizes
	localparam int GPR_COUNT = 16;
	localparam int GPR_LEGACY_COUNT = 8;
	localparam int SEG_COUNT = 6;
	localparam int XREG_MAX = 8;

	// Status flag bit positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_ZERO = 6;
	localparam int FLAG_SIGN = 7;
	localparam int FLAG_OVERFLOW = 11;

	// Reset values
	localparam logic [63:0] FLAGS_RESET = 64'h0000_0000_0000_0002;
	localparam logic [63:0] IP_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
	localparam logic [15:0] SEG_RESET = 16'h0000;

	// Condition field encodings, one code per alternate-name pair
	localparam logic [3:0] COND_OVERFLOW = 4'h0;
	localparam logic [3:0] COND_NO_OVERFLOW = 4'h1;
	localparam logic [3:0] COND_BELOW = 4'h2;
	localparam logic [3:0] COND_ABOVE_EQ = 4'h3;
	localparam logic [3:0] COND_EQUAL = 4'h4;
	localparam logic [3:0] COND_NOT_EQUAL = 4'h5;
	localparam logic [3:0] COND_BELOW_EQ = 4'h6;
	localparam logic [3:0] COND_ABOVE = 4'h7;
	localparam logic [3:0] COND_SIGN = 4'h8;
	localparam logic [3:0] COND_NO_SIGN = 4'h9;
	localparam logic [3:0] COND_PARITY = 4'hA;
	localparam logic [3:0] COND_NO_PARITY = 4'hB;
	localparam logic [3:0] COND_LESS = 4'hC;
	localparam logic [3:0] COND_GREATER_EQ = 4'hD;
	localparam logic [3:0] COND_LESS_EQ = 4'hE;
	localparam logic [3:0] COND_GREATER = 4'hF;

	// Fault codes reported with a refused request
	localparam logic [3:0] FAULT_NONE = 4'h0;
	localparam logic [3:0] FAULT_MODE = 4'h1;
	localparam logic [3:0] FAULT_PATH = 4'h2;
	localparam logic [3:0] FAULT_REG = 4'h3;
	localparam logic [3:0] FAULT_WIDTH = 4'h4;

	// Instruction classes
	typedef enum logic [1:0] {
		OP_COPY,
		OP_GATED,
		OP_LEGACY_ONLY,
		OP_NONE
	} op_t;

	// Operand locations
	typedef enum logic [2:0] {
		LOC_GPR,
		LOC_SEG,
		LOC_MEM,
		LOC_IMM,
		LOC_CTRL,
		LOC_DBG
	} loc_t;

	// Operand widths
	typedef enum logic [1:0] {
		W8,
		W16,
		W32,
		W64
	} width_t;

	// One decoded instruction
	typedef struct packed {
		op_t op;
		loc_t src;
		loc_t dst;
		logic [3:0] src_idx;
		logic [3:0] dst_idx;
		width_t width;
		logic register_extension_prefix;
		logic prefix_wide;
		logic [3:0] cond;
		logic [63:0] imm;
		logic [3:0] instr_len;
	} req_t;

	// Memory store towards the memory system
	typedef struct packed {
		logic we;
		width_t width;
		logic [63:0] data;
	} mem_wr_t;

	// Completion report
	typedef struct packed {
		logic done;
		logic fault;
		logic [3:0] code;
		logic moved;
	} resp_t;

endpackage

// File: design/cond_eval.sv
// Condition field evaluation against the status flags
`timescale 1ns/1ps
module cond_eval (
	// Inputs
	input wire logic [3:0] cond,
	input wire logic [63:0] flags,
	// Result
	output logic holds
);

	// Individual flag bits
	logic cf;
	logic pf;
	logic zf;
	logic sf;
	logic of;

	// Decode one condition code
	always_comb begin
		cf = flags[data_move_pkg::FLAG_CARRY];
		pf = flags[data_move_pkg::FLAG_PARITY];
		zf = flags[data_move_pkg::FLAG_ZERO];
		sf = flags[data_move_pkg::FLAG_SIGN];
		of = flags[data_move_pkg::FLAG_OVERFLOW];
		case (cond)
			data_move_pkg::COND_OVERFLOW: holds = of;
			data_move_pkg::COND_NO_OVERFLOW: holds = !of;
			data_move_pkg::COND_BELOW: holds = cf;
			data_move_pkg::COND_ABOVE_EQ: holds = !cf;
			data_move_pkg::COND_EQUAL: holds = zf;
			data_move_pkg::COND_NOT_EQUAL: holds = !zf;
			data_move_pkg::COND_BELOW_EQ: holds = cf | zf;
			data_move_pkg::COND_ABOVE: holds = !(cf | zf);
			data_move_pkg::COND_SIGN: holds = sf;
			data_move_pkg::COND_NO_SIGN: holds = !sf;
			data_move_pkg::COND_PARITY: holds = pf;
			data_move_pkg::COND_NO_PARITY: holds = !pf;
			data_move_pkg::COND_LESS: holds = sf ^ of;
			data_move_pkg::COND_GREATER_EQ: holds = !(sf ^ of);
			data_move_pkg::COND_LESS_EQ: holds = (sf ^ of) | zf;
			default: holds = !((sf ^ of) | zf);
		endcase
	end

endmodule

// File: design/data_move_unit.sv
// Register environment with plain and flag-gated copy execution
`timescale 1ns/1ps
module data_move_unit #(
	parameter int XREG_COUNT = 8
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// Mode
	input wire logic MODE64,
	// Instruction request
	input wire logic REQ_VALID,
	input wire data_move_pkg::req_t REQ,
	// Load operand from memory system
	input wire logic [63:0] MEM_RDATA,
	// Flag update from the arithmetic side
	input wire logic FLAGS_LOAD,
	input wire logic [63:0] FLAGS_IN,
	// Register readback select
	input wire logic [3:0] RD_SEL,
	// Completion
	output data_move_pkg::resp_t RESP,
	// Store towards memory system
	output data_move_pkg::mem_wr_t MEM_WR,
	// Architectural state views
	output logic [63:0] RD_DATA,
	output logic [63:0] FLAGS_OUT,
	output logic [63:0] IP_OUT,
	output logic [15:0] SEG_OUT,
	output logic GATED_COPY_FEATURE
);

	// Refuse sizes the index fields cannot serve
	if (XREG_COUNT < 1 || XREG_COUNT > data_move_pkg::XREG_MAX) begin : g_chk
		$error("XREG_COUNT must be 1 to 8");
	end

	// Whole module state
	typedef struct packed {
		logic [data_move_pkg::GPR_COUNT-1:0][63:0] gpr;
		logic [data_move_pkg::SEG_COUNT-1:0][15:0] seg;
		logic [XREG_COUNT-1:0][63:0] ctrl;
		logic [XREG_COUNT-1:0][63:0] dbg;
		logic [63:0] flags;
		logic [63:0] ip;
		data_move_pkg::resp_t resp;
		data_move_pkg::mem_wr_t mem_wr;
		logic [63:0] rd_data;
		logic [15:0] seg_out;
		logic feature;
	} state_t;

	state_t st;
	state_t next_st;

	// Reset synchroniser stages
	logic rst_meta;
	logic rst_sync;

	// Condition evaluator result
	logic cond_holds;

	// Release reset through two flip-flops
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			// Pin low: hold the internal copy in reset
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Flag test for gated copy
	cond_eval u_cond (
		.cond(REQ.cond),
		.flags(st.flags),
		.holds(cond_holds)
	);

	// Is a general register index reachable in this mode
	function automatic logic gpr_ok(input logic [3:0] idx, input logic m64,
			input logic ext);
		gpr_ok = (idx < 4'(data_move_pkg::GPR_LEGACY_COUNT)) ||
			(m64 && ext);
	endfunction

	// Is an index valid for its location
	function automatic logic idx_ok(input data_move_pkg::loc_t loc,
			input logic [3:0] idx, input logic m64, input logic ext);
		if (loc == data_move_pkg::LOC_GPR) begin
			idx_ok = gpr_ok(idx, m64, ext);
		end else if (loc == data_move_pkg::LOC_SEG) begin
			idx_ok = idx < 4'(data_move_pkg::SEG_COUNT);
		end else if (loc == data_move_pkg::LOC_CTRL ||
				loc == data_move_pkg::LOC_DBG) begin
			idx_ok = idx < 4'(XREG_COUNT);
		end else begin
			idx_ok = 1'b1;
		end
	endfunction

	// Legal source to destination pairs of the plain copy
	function automatic logic path_ok(input data_move_pkg::loc_t s,
			input data_move_pkg::loc_t d);
		// Any pair not listed below is refused
		path_ok = 1'b0;
		if (s == data_move_pkg::LOC_MEM) begin
			path_ok = d == data_move_pkg::LOC_GPR ||
				d == data_move_pkg::LOC_SEG;
		end else if (s == data_move_pkg::LOC_GPR) begin
			path_ok = d != data_move_pkg::LOC_IMM;
		end else if (s == data_move_pkg::LOC_SEG) begin
			path_ok = d == data_move_pkg::LOC_GPR ||
				d == data_move_pkg::LOC_MEM;
		end else if (s == data_move_pkg::LOC_IMM) begin
			path_ok = d == data_move_pkg::LOC_GPR ||
				d == data_move_pkg::LOC_MEM;
		end else if (s == data_move_pkg::LOC_CTRL ||
				s == data_move_pkg::LOC_DBG) begin
			path_ok = d == data_move_pkg::LOC_GPR;
		end
	endfunction

	// Merge a written value into an old register by width
	function automatic logic [63:0] merge(input logic [63:0] old_v,
			input logic [63:0] new_v, input data_move_pkg::width_t w,
			input logic m64);
		// Narrow writes keep upper bits, 32-bit clears them
		case (w)
			data_move_pkg::W8: merge = {old_v[63:8], new_v[7:0]};
			data_move_pkg::W16: merge = {old_v[63:16], new_v[15:0]};
			data_move_pkg::W32: merge = {32'h0000_0000, new_v[31:0]};
			default: merge = m64 ? new_v : {32'h0000_0000, new_v[31:0]};
		endcase
	endfunction

	// Cut a value to the operand width
	function automatic logic [63:0] trim(input logic [63:0] v,
			input data_move_pkg::width_t w);
		case (w)
			data_move_pkg::W8: trim = {56'h0, v[7:0]};
			data_move_pkg::W16: trim = {48'h0, v[15:0]};
			data_move_pkg::W32: trim = {32'h0, v[31:0]};
			default: trim = v;
		endcase
	endfunction

	// Next state
	always_comb begin
		// Working values of this request
		logic [63:0] src_val;
		logic [3:0] code;
		logic do_write;
		logic [63:0] ip_sum;
		next_st = st;
		src_val = 64'h0;
		code = data_move_pkg::FAULT_NONE;
		do_write = 1'b0;
		ip_sum = 64'h0;
		// Pulses default low
		next_st.resp = '0;
		next_st.mem_wr.we = 1'b0;
		next_st.feature = 1'b1;

		// Fetch source operand
		case (REQ.src)
			data_move_pkg::LOC_GPR: src_val = st.gpr[REQ.src_idx];
			data_move_pkg::LOC_SEG: begin
				src_val = {48'h0, st.seg[3'(REQ.src_idx)]};
			end
			data_move_pkg::LOC_MEM: src_val = MEM_RDATA;
			data_move_pkg::LOC_IMM: src_val = REQ.imm;
			data_move_pkg::LOC_CTRL: begin
				src_val = st.ctrl[3'(REQ.src_idx)];
			end
			default: src_val = st.dbg[3'(REQ.src_idx)];
		endcase
		// Operand cut to its width before any use
		src_val = trim(src_val, REQ.width);

		// Legality checks in priority order
		if (REQ.op == data_move_pkg::OP_LEGACY_ONLY && MODE64) begin
			code = data_move_pkg::FAULT_MODE;
		end else if (REQ.op == data_move_pkg::OP_NONE) begin
			code = data_move_pkg::FAULT_MODE;
		end else if (REQ.op == data_move_pkg::OP_LEGACY_ONLY) begin
			code = data_move_pkg::FAULT_NONE;
		end else if (!idx_ok(REQ.src, REQ.src_idx, MODE64,
				REQ.register_extension_prefix) ||
				!idx_ok(REQ.dst, REQ.dst_idx, MODE64,
				REQ.register_extension_prefix)) begin
			code = data_move_pkg::FAULT_REG;
		end else if (REQ.width == data_move_pkg::W64 &&
				!(MODE64 && REQ.prefix_wide)) begin
			code = data_move_pkg::FAULT_WIDTH;
		end else if (REQ.op == data_move_pkg::OP_GATED) begin
			// Register destination, register or memory source
			if (REQ.dst != data_move_pkg::LOC_GPR ||
					!(REQ.src == data_move_pkg::LOC_GPR ||
					REQ.src == data_move_pkg::LOC_MEM)) begin
				code = data_move_pkg::FAULT_PATH;
			end else if (REQ.width == data_move_pkg::W8) begin
				code = data_move_pkg::FAULT_WIDTH;
			end
		end else if (!path_ok(REQ.src, REQ.dst)) begin
			code = data_move_pkg::FAULT_PATH;
		end

		// Write enable: gated copy needs its condition
		if (code == data_move_pkg::FAULT_NONE) begin
			if (REQ.op == data_move_pkg::OP_COPY) begin
				do_write = 1'b1;
			end else if (REQ.op == data_move_pkg::OP_GATED) begin
				do_write = cond_holds;
			end
		end

		// Execute one request
		if (REQ_VALID) begin
			next_st.resp.done = 1'b1;
			next_st.resp.fault = code != data_move_pkg::FAULT_NONE;
			next_st.resp.code = code;
			next_st.resp.moved = do_write;
			// Destination changes only when the copy happens
			if (do_write) begin
				case (REQ.dst)
					data_move_pkg::LOC_GPR: begin
						next_st.gpr[REQ.dst_idx] = merge(st.gpr[REQ.dst_idx],
							src_val, REQ.width, MODE64);
					end
					data_move_pkg::LOC_SEG: begin
						next_st.seg[3'(REQ.dst_idx)] = src_val[15:0];
					end
					data_move_pkg::LOC_MEM: begin
						next_st.mem_wr.we = 1'b1;
						next_st.mem_wr.width = REQ.width;
						next_st.mem_wr.data = src_val;
					end
					data_move_pkg::LOC_CTRL: begin
						next_st.ctrl[3'(REQ.dst_idx)] = src_val;
					end
					data_move_pkg::LOC_DBG: begin
						next_st.dbg[3'(REQ.dst_idx)] = src_val;
					end
					default: begin
						next_st.mem_wr.we = 1'b0;
					end
				endcase
			end
			// Pointer moves past every accepted instruction
			// A refused request leaves it where it was
			if (code == data_move_pkg::FAULT_NONE) begin
				ip_sum = st.ip + {60'h0, REQ.instr_len};
				next_st.ip = MODE64 ? ip_sum :
					{32'h0000_0000, ip_sum[31:0]};
			end
		end

		// Flags change only from the arithmetic side
		if (FLAGS_LOAD) begin
			next_st.flags = MODE64 ? FLAGS_IN :
				{32'h0000_0000, FLAGS_IN[31:0]};
		end

		// Readback views, narrow outside 64-bit mode
		if (MODE64) begin
			next_st.rd_data = st.gpr[RD_SEL];
		end else begin
			// Only the low eight registers, low half
			next_st.rd_data = {32'h0000_0000,
				st.gpr[{1'b0, RD_SEL[2:0]}][31:0]};
		end
		// Segment view reads zero past the last segment
		if (RD_SEL < 4'(data_move_pkg::SEG_COUNT)) begin
			next_st.seg_out = st.seg[3'(RD_SEL)];
		end else begin
			next_st.seg_out = data_move_pkg::SEG_RESET;
		end
	end

	// State register
	always_ff @(posedge MCLK or negedge rst_sync) begin
		if (!rst_sync) begin
			// Clear all, then apply the reset values
			st <= '0;
			st.gpr <= {data_move_pkg::GPR_COUNT{data_move_pkg::REG_RESET}};
			st.flags <= data_move_pkg::FLAGS_RESET;
			st.ip <= data_move_pkg::IP_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign RESP = st.resp;
	assign MEM_WR = st.mem_wr;
	assign RD_DATA = st.rd_data;
	assign FLAGS_OUT = st.flags;
	assign IP_OUT = st.ip;
	assign SEG_OUT = st.seg_out;
	assign GATED_COPY_FEATURE = st.feature;

endmodule

// File: test/mem_partner.sv
// Memory side model holding one operand word
`timescale 1ns/1ps
module mem_partner (
	// Clock
	input wire logic MCLK,
	// Load strobe and store port
	input wire logic rd,
	input wire data_move_pkg::mem_wr_t wr,
	// Load data
	output logic [63:0] rdata
);
	// Last stored word
	logic [63:0] word;
	// Capture a store on its strobe cycle
	always @(posedge MCLK) begin
		if (wr.we) begin
			word <= wr.data;
		end
	end
	// Outside a load the bus shows the inverse, never stale data
	assign rdata = rd ? word : ~word;
endmodule

// File: test/data_move_assertions.sv
// Port assertions for the data move unit
`timescale 1ns/1ps
module data_move_checker (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// Request side
	input wire logic MODE64,
	input wire logic REQ_VALID,
	input wire data_move_pkg::req_t REQ,
	input wire logic FLAGS_LOAD,
	// Results
	input wire data_move_pkg::resp_t RESP,
	input wire data_move_pkg::mem_wr_t MEM_WR,
	input wire logic [63:0] FLAGS_OUT,
	input wire logic [63:0] IP_OUT,
	input wire logic GATED_COPY_FEATURE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// Plain copy request this edge
	wire cp = REQ_VALID && REQ.op == data_move_pkg::OP_COPY;
	// Register to register path
	wire gg = REQ.src == data_move_pkg::LOC_GPR &&
		REQ.dst == data_move_pkg::LOC_GPR;
	resp_follows_a: assert property (
		REQ_VALID |=> RESP.done) else $error("no completion");
	idle_quiet_a: assert property (
		!REQ_VALID |=> !RESP.done && !MEM_WR.we) else $error("stray pulse");
	mem_pair_a: assert property (
		cp && REQ.src == data_move_pkg::LOC_MEM &&
		REQ.dst == data_move_pkg::LOC_MEM && REQ.width == data_move_pkg::W32
		|=> RESP.code == data_move_pkg::FAULT_PATH) else $error("mem copy");
	seg_pair_a: assert property (
		cp && REQ.src == data_move_pkg::LOC_SEG && REQ.src_idx < 6 &&
		REQ.dst == data_move_pkg::LOC_SEG && REQ.dst_idx < 6 &&
		REQ.width == data_move_pkg::W16
		|=> RESP.code == data_move_pkg::FAULT_PATH) else $error("seg copy");
	legacy_refused_a: assert property (
		REQ_VALID && MODE64 && REQ.op == data_move_pkg::OP_LEGACY_ONLY
		|=> RESP.fault && RESP.code == data_move_pkg::FAULT_MODE)
		else $error("legacy op taken");
	upper_reg_a: assert property (
		cp && gg && !MODE64 && REQ.dst_idx[3] && !REQ.src_idx[3]
		|=> RESP.code == data_move_pkg::FAULT_REG) else $error("upper reg");
	wide_width_a: assert property (
		cp && gg && MODE64 && !REQ.prefix_wide &&
		REQ.width == data_move_pkg::W64 && !REQ.src_idx[3] && !REQ.dst_idx[3]
		|=> RESP.code == data_move_pkg::FAULT_WIDTH) else $error("wide op");
	flags_kept_a: assert property (
		!FLAGS_LOAD |=> $stable(FLAGS_OUT)) else $error("flags moved");
	ip_step_a: assert property (
		RESP.done |-> IP_OUT == $past(IP_OUT) +
		(RESP.fault ? 4'h0 : $past(REQ.instr_len))) else $error("ip step");
	store_pulse_a: assert property (
		MEM_WR.we |-> RESP.done && !RESP.fault && RESP.moved)
		else $error("bad store");
	feature_set_a: assert property (
		RSTN [*4] |-> GATED_COPY_FEATURE) else $error("feature low");
	// Main scenarios
	moved_c: cover property (REQ_VALID ##1 RESP.moved);
	skip_c: cover property (REQ.op == data_move_pkg::OP_GATED &&
		REQ_VALID ##1 !RESP.moved);
	fault_c: cover property (RESP.fault);
endmodule
bind data_move_unit data_move_checker data_move_checker_i (
	.MCLK(MCLK), .RSTN(RSTN), .MODE64(MODE64), .REQ_VALID(REQ_VALID),
	.REQ(REQ), .FLAGS_LOAD(FLAGS_LOAD), .RESP(RESP), .MEM_WR(MEM_WR),
	.FLAGS_OUT(FLAGS_OUT), .IP_OUT(IP_OUT),
	.GATED_COPY_FEATURE(GATED_COPY_FEATURE)
);

// File: test/gp_data_move_unit_bench.sv
// Self-checking bench for the data move unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
	end \
end
module gp_data_move_unit_bench;
	// Design inputs
	logic MCLK = 1'b0;
	logic RSTN = 1'b0;
	logic MODE64 = 1'b0;
	logic REQ_VALID = 1'b0;
	data_move_pkg::req_t REQ = '0;
	logic FLAGS_LOAD = 1'b0;
	logic [63:0] FLAGS_IN = '0;
	logic [3:0] RD_SEL = '0;
	// Design outputs and memory model load data
	wire [63:0] MEM_RDATA;
	data_move_pkg::resp_t RESP;
	data_move_pkg::mem_wr_t MEM_WR;
	logic [63:0] RD_DATA, FLAGS_OUT, IP_OUT;
	logic [15:0] SEG_OUT;
	logic FEAT;
	// Counters and expected state
	int n_mismatch = 0;
	int check_count = 0;
	logic [63:0] g [16];
	logic [63:0] ip, fl, mw;
	data_move_pkg::resp_t rsp;
	data_move_pkg::mem_wr_t wr;
	data_move_pkg::req_t r;
	logic hit;
	wire mrd = REQ_VALID && REQ.src == data_move_pkg::LOC_MEM;
	always #20 MCLK = ~MCLK;
	data_move_unit data_move_unit_i (.MCLK(MCLK), .RSTN(RSTN),
		.MODE64(MODE64), .REQ_VALID(REQ_VALID), .REQ(REQ),
		.MEM_RDATA(MEM_RDATA), .FLAGS_LOAD(FLAGS_LOAD), .FLAGS_IN(FLAGS_IN),
		.RD_SEL(RD_SEL), .RESP(RESP), .MEM_WR(MEM_WR), .RD_DATA(RD_DATA),
		.FLAGS_OUT(FLAGS_OUT), .IP_OUT(IP_OUT), .SEG_OUT(SEG_OUT),
		.GATED_COPY_FEATURE(FEAT));
	mem_partner mem_partner_i (.MCLK(MCLK), .rd(mrd), .wr(MEM_WR),
		.rdata(MEM_RDATA));
	// Condition outcome from the flags
	function automatic logic holds(input logic [3:0] c, input logic [63:0] f);
		logic cf, pf, zf, sf, of, t;
		cf = f[data_move_pkg::FLAG_CARRY];
		pf = f[data_move_pkg::FLAG_PARITY];
		zf = f[data_move_pkg::FLAG_ZERO];
		sf = f[data_move_pkg::FLAG_SIGN];
		of = f[data_move_pkg::FLAG_OVERFLOW];
		case (c[3:1])
			3'h0: t = of;
			3'h1: t = cf;
			3'h2: t = zf;
			3'h3: t = cf | zf;
			3'h4: t = sf;
			3'h5: t = pf;
			3'h6: t = sf ^ of;
			default: t = (sf ^ of) | zf;
		endcase
		return t ^ c[0];
	endfunction
	// Request builder with random immediate and length
	function automatic data_move_pkg::req_t mk(input data_move_pkg::op_t o,
		input data_move_pkg::loc_t s, d, input logic [3:0] si, di,
		input data_move_pkg::width_t w);
		mk = '0;
		mk.op = o;
		mk.src = s;
		mk.dst = d;
		mk.src_idx = si;
		mk.dst_idx = di;
		mk.width = w;
		mk.imm = {$urandom, $urandom};
		mk.instr_len = 4'($urandom_range(1, 15));
	endfunction
	// One request, checked at completion
	task automatic issue(input data_move_pkg::req_t q, input logic [3:0] code);
		REQ = q;
		REQ_VALID = 1'b1;
		@(negedge MCLK);
		REQ_VALID = 1'b0;
		rsp = RESP;
		wr = MEM_WR;
		if (code == data_move_pkg::FAULT_NONE) begin
			ip = ip + q.instr_len;
		end
		`CHK("done", 1'b1, rsp.done)
		`CHK("code", code, rsp.code)
		`CHK("fault", code != data_move_pkg::FAULT_NONE,
			rsp.fault)
		`CHK("ip", ip, IP_OUT)
		`CHK("flags kept", fl, FLAGS_OUT)
		@(negedge MCLK);
	endtask
	// Immediate into a register, read back
	task automatic put(input int i);
		r = mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_IMM,
			data_move_pkg::LOC_GPR, 4'h0, i[3:0], data_move_pkg::W32);
		RD_SEL = i[3:0];
		issue(r, data_move_pkg::FAULT_NONE);
		g[i] = {32'h0, r.imm[31:0]};
		`CHK("gpr", g[i], RD_DATA)
	endtask
	// Load new flags
	task automatic setfl(input logic [63:0] v);
		FLAGS_IN = v;
		FLAGS_LOAD = 1'b1;
		@(negedge MCLK);
		FLAGS_LOAD = 1'b0;
		fl = MODE64 ? v : {32'h0, v[31:0]};
		`CHK("flags", fl, FLAGS_OUT)
	endtask
	// Closing report
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge MCLK);
		n_mismatch++;
		print_verdict();
	end
	// Main sequence
	initial begin
		void'($urandom(46616));
		repeat (10) @(negedge MCLK);
		RSTN = 1'b1;
		repeat (4) @(negedge MCLK);
		ip = '0;
		fl = 64'h2;
		`CHK("flags rst", 64'h2, FLAGS_OUT)
		`CHK("ip rst", 64'h0, IP_OUT)
		`CHK("feature", 1'b1, FEAT)
		for (int i = 0; i < 8; i++) begin
			put(i);
		end
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			RD_SEL = i[3:0];
			issue(mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_GPR,
				data_move_pkg::LOC_SEG, 4'h1, i[3:0], data_move_pkg::W16),
				data_move_pkg::FAULT_NONE);
			`CHK("seg", g[1][15:0], SEG_OUT)
		end
		RD_SEL = 4'h6;
		@(negedge MCLK);
		`CHK("seg none", 16'h0, SEG_OUT)
		$display("test segments done");
		issue(mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_GPR,
			data_move_pkg::LOC_MEM, 4'h1, 4'h0, data_move_pkg::W32),
			data_move_pkg::FAULT_NONE);
		mw = {32'h0, g[1][31:0]};
		`CHK("store we", 1'b1, wr.we)
		`CHK("store data", mw, wr.data)
		`CHK("store width", data_move_pkg::W32, wr.width)
		RD_SEL = 4'h3;
		issue(mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_MEM,
			data_move_pkg::LOC_GPR, 4'h0, 4'h3, data_move_pkg::W32),
			data_move_pkg::FAULT_NONE);
		`CHK("load", mw, RD_DATA)
		issue(mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_MEM,
			data_move_pkg::LOC_MEM, 4'h0, 4'h0, data_move_pkg::W32),
			data_move_pkg::FAULT_PATH);
		issue(mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_SEG,
			data_move_pkg::LOC_SEG, 4'h0, 4'h1, data_move_pkg::W16),
			data_move_pkg::FAULT_PATH);
		issue(mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_GPR,
			data_move_pkg::LOC_GPR, 4'h0, 4'h9, data_move_pkg::W32),
			data_move_pkg::FAULT_REG);
		$display("test paths done");
		for (int c = 0; c < 16; c++) begin
			put(2);
			setfl({$urandom, $urandom} | 64'h2);
			r = mk(data_move_pkg::OP_GATED, data_move_pkg::LOC_GPR,
				data_move_pkg::LOC_GPR, 4'h1, 4'h2, data_move_pkg::W32);
			if (c[0]) begin
				r.src = data_move_pkg::LOC_MEM;
				r.width = data_move_pkg::W16;
			end
			r.cond = c[3:0];
			issue(r, data_move_pkg::FAULT_NONE);
			hit = holds(c[3:0], fl);
			`CHK("moved", hit, rsp.moved)
			if (hit) begin
				g[2] = c[0] ? {g[2][63:16], mw[15:0]} : {32'h0, g[1][31:0]};
			end
			`CHK("gated", g[2], RD_DATA)
		end
		$display("test gated done");
		for (int k = 0; k < 2; k++) begin
			r = mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_GPR,
				data_move_pkg::LOC_CTRL, 4'h1, 4'h7, data_move_pkg::W32);
			if (k == 1) begin
				r.dst = data_move_pkg::LOC_DBG;
			end
			issue(r, data_move_pkg::FAULT_NONE);
			r.src = r.dst;
			r.dst = data_move_pkg::LOC_GPR;
			r.src_idx = 4'h7;
			r.dst_idx = 4'h4;
			RD_SEL = 4'h4;
			issue(r, data_move_pkg::FAULT_NONE);
			g[4] = {32'h0, g[1][31:0]};
			`CHK("xreg", g[4], RD_DATA)
		end
		r = mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_SEG,
			data_move_pkg::LOC_GPR, 4'h0, 4'h5, data_move_pkg::W16);
		RD_SEL = 4'h5;
		issue(r, data_move_pkg::FAULT_NONE);
		g[5] = {g[5][63:16], g[1][15:0]};
		`CHK("seg load", g[5], RD_DATA)
		r = mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_IMM,
			data_move_pkg::LOC_MEM, 4'h0, 4'h0, data_move_pkg::W32);
		issue(r, data_move_pkg::FAULT_NONE);
		mw = {32'h0, r.imm[31:0]};
		`CHK("imm store", mw, wr.data)
		r.op = data_move_pkg::OP_NONE;
		issue(r, data_move_pkg::FAULT_MODE);
		r.op = data_move_pkg::OP_LEGACY_ONLY;
		issue(r, data_move_pkg::FAULT_NONE);
		r.op = data_move_pkg::OP_GATED;
		issue(r, data_move_pkg::FAULT_PATH);
		r.src = data_move_pkg::LOC_GPR;
		r.dst = data_move_pkg::LOC_GPR;
		r.width = data_move_pkg::W8;
		issue(r, data_move_pkg::FAULT_WIDTH);
		r.op = data_move_pkg::OP_COPY;
		r.dst = data_move_pkg::LOC_IMM;
		r.width = data_move_pkg::W32;
		issue(r, data_move_pkg::FAULT_PATH);
		r.dst = data_move_pkg::LOC_CTRL;
		r.dst_idx = 4'h8;
		issue(r, data_move_pkg::FAULT_REG);
		$display("test extra paths done");
		MODE64 = 1'b1;
		@(negedge MCLK);
		setfl({$urandom, $urandom} | 64'h2);
		r = mk(data_move_pkg::OP_COPY, data_move_pkg::LOC_IMM,
			data_move_pkg::LOC_GPR, 4'h0, 4'hC, data_move_pkg::W64);
		r.register_extension_prefix = 1'b1;
		r.prefix_wide = 1'b1;
		RD_SEL = 4'hC;
		issue(r, data_move_pkg::FAULT_NONE);
		`CHK("wide gpr", r.imm, RD_DATA)
		r.prefix_wide = 1'b0;
		issue(r, data_move_pkg::FAULT_WIDTH);
		r.op = data_move_pkg::OP_LEGACY_ONLY;
		issue(r, data_move_pkg::FAULT_MODE);
		MODE64 = 1'b0;
		$display("test wide mode done");
		print_verdict();
	end
endmodule
